// *** rtl/modem_cfg_pkg.sv ***
`default_nettype none
package modem_cfg_pkg;

    // ************************************************************
    // Configuration byte offsets
    // ************************************************************
    localparam logic [7:0]  OFS_COMMAND     = 8'h04;
    localparam logic [7:0]  OFS_CONDITION   = 8'h06;
    localparam logic [7:0]  OFS_REVISION    = 8'h08;
    localparam logic [7:0]  OFS_PROG_IF     = 8'h09;
    localparam logic [7:0]  OFS_SUBCLASS    = 8'h0a;
    localparam logic [7:0]  OFS_BASE_CLASS  = 8'h0b;
    localparam logic [7:0]  OFS_HEADER      = 8'h0e;
    localparam logic [7:0]  OFS_MIXER_BASE  = 8'h10;

    // ************************************************************
    // Reset and fixed values
    // ************************************************************
    localparam logic [15:0] CONDITION_RESET = 16'h0280;
    localparam logic [15:0] COMMAND_RESET   = 16'h0000;
    localparam logic [7:0]  PROG_IF_VALUE   = 8'h00;
    localparam logic [7:0]  SUBCLASS_VALUE  = 8'h03;
    localparam logic [7:0]  BASE_CLASS_VAL  = 8'h07;
    localparam logic [7:0]  HEADER_VALUE    = 8'h00;
    localparam logic [31:0] MIXER_RESET     = 32'h0000_0001;
    localparam logic [7:0]  MIXER_BASE_RST  = 8'h00;

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int          ABORT_BIT       = 13;
    localparam int          SPEED_LSB       = 9;
    localparam int          B2B_BIT         = 7;
    localparam int          DECODE_EN_BIT   = 0;
    localparam int          BASE_LSB        = 8;
    localparam int          SPLIT_BIT       = 7;

endpackage
`default_nettype wire

// *** rtl/flag_w1c.sv ***
`timescale 1ns/10ps
`default_nettype none
module flag_w1c (
    input  wire logic clock_in,
    input  wire logic rst_n_in,
    input  wire logic set_in,
    input  wire logic clear_in,
    output logic      flag_out
);
    // ************************************************************
    // Sticky flag, set beats clear
    // ************************************************************
    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            flag_out <= 1'b0;
        end else if (set_in) begin
            flag_out <= 1'b1; // R3 R19
        end else if (clear_in) begin
            flag_out <= 1'b0; // R4
        end
    end
endmodule
`default_nettype wire

// *** rtl/mixer_window_decode.sv ***
`timescale 1ns/10ps
`default_nettype none
module mixer_window_decode (
    input  wire logic       enable_in,
    input  wire logic [7:0] base_in,
    input  wire logic [15:0] addr_in,
    output logic            hit_out,
    output logic            secondary_out,
    output logic [6:0]      offset_out
);
    import modem_cfg_pkg::*;

    // ************************************************************
    // 256-byte window, halves split between codecs
    // ************************************************************
    assign hit_out       = enable_in && (addr_in[15:BASE_LSB] == base_in); // R15 R18
    assign secondary_out = addr_in[SPLIT_BIT];                             // R17
    assign offset_out    = addr_in[6:0];
endmodule
`default_nettype wire

// *** rtl/modem_pci_config_header.sv ***
// Summary of operation
// R1: Device condition register is 16 bits, resets to 0280h.
// R2: Bits 15, 14, 11, 8 and 6 read zero, writes ignored.
// R3: Master abort by own bus transaction sets initiator abort flag, bit 13.
// R4: Writing one to bit 13 clears the flag; zero leaves it.
// R5: Decode speed field at bits 10:9 is read-only.
// R6: Bit 7 reads one: back-to-back capable as target.
// R7: Bit 5 and reserved bits 12, 4:0 read zero.
// R8: Read-only revision code at offset 08h.
// R9: Programming interface byte 00h at offset 09h.
// R10: Subclass byte 03h at offset 0Ah.
// R11: Base class byte 07h at offset 0Bh.
// R12: Header layout byte 00h at offset 0Eh.
// R13: Mixer window base is 32 bits at 10h, resets to 00000001h.
// R14: Mixer base bit 0 is constant one, marking I/O space.
// R15: Bits 15:8 writable, 31:16 and 7:1 zero; 256-byte window.
// R16: Window hits are forwarded to the codec, nothing held locally. A hit while one access is in flight is left unclaimed.
// R17: Offsets 00h-7Fh go to primary codec, 80h-FFh to secondary.
// R18: I/O decode only while command bit 0 is one; reset zero.
// R19: Abort in same cycle as clearing write keeps the flag set.
`timescale 1ns/10ps
`default_nettype none
module modem_pci_config_header #(
    parameter logic [7:0] REVISION_CODE = 8'h00 // Arbitrary value
) (
    input  wire logic        clock_in,
    input  wire logic        rst_n_in,
    input  wire logic        cfg_rd_in,
    input  wire logic        cfg_wr_in,
    input  wire logic [5:0]  cfg_dw_addr_in,
    input  wire logic [3:0]  cfg_be_in,
    input  wire logic [31:0] cfg_wdata_in,
    output logic             cfg_ack_out,
    output logic [31:0]      cfg_rdata_out,
    input  wire logic        master_abort_in,
    input  wire logic        io_req_in,
    input  wire logic        io_wr_in,
    input  wire logic [15:0] io_addr_in,
    input  wire logic [15:0] io_wdata_in,
    output logic             io_claim_out,
    output logic             io_done_out,
    output logic [15:0]      io_rdata_out,
    output logic             codec_req_out,
    output logic             codec_wr_out,
    output logic             codec_secondary_out,
    output logic [6:0]       codec_offset_out,
    output logic [15:0]      codec_wdata_out,
    input  wire logic        codec_done_in,
    input  wire logic [15:0] codec_rdata_in
);
    import modem_cfg_pkg::*;

    localparam logic [5:0] DW_COMMAND = OFS_COMMAND[7:2];
    localparam logic [5:0] DW_CLASS   = OFS_REVISION[7:2];
    localparam logic [5:0] DW_HEADER  = OFS_HEADER[7:2];
    localparam logic [5:0] DW_MIXER   = OFS_MIXER_BASE[7:2];

    logic        io_enable_reg;
    logic [7:0]  mixer_base_reg;
    logic        abort_flag;
    logic        abort_clear;
    logic [15:0] condition_value;
    logic [15:0] command_value;
    logic [31:0] mixer_value;
    logic [31:0] cfg_rdata_next;
    logic        win_hit;
    logic        win_secondary;
    logic [6:0]  win_offset;
    logic        busy_reg;
    logic        wr_cmd;
    logic        wr_mixer;

    // ************************************************************
    // Configuration writes
    // ************************************************************
    assign wr_cmd      = cfg_wr_in && (cfg_dw_addr_in == DW_COMMAND);
    assign wr_mixer    = cfg_wr_in && (cfg_dw_addr_in == DW_MIXER);
    assign abort_clear = wr_cmd && cfg_be_in[3] && cfg_wdata_in[16 + ABORT_BIT]; // R4

    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            io_enable_reg <= COMMAND_RESET[DECODE_EN_BIT]; // R18
        end else if (wr_cmd && cfg_be_in[0]) begin
            io_enable_reg <= cfg_wdata_in[DECODE_EN_BIT]; // R18
        end
    end

    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            mixer_base_reg <= MIXER_BASE_RST; // R13
        end else if (wr_mixer && cfg_be_in[1]) begin
            mixer_base_reg <= cfg_wdata_in[15:BASE_LSB]; // R15
        end
    end

    flag_w1c abort_flag_inst (
        .clock_in (clock_in),
        .rst_n_in (rst_n_in),
        .set_in   (master_abort_in),
        .clear_in (abort_clear),
        .flag_out (abort_flag)
    );

    // ************************************************************
    // Read values
    // ************************************************************
    // Fixed bits all come from the reset pattern; only the flag moves
    assign condition_value = CONDITION_RESET
                           | ({15'h0000, abort_flag} << ABORT_BIT); // R1 R2 R5 R6 R7
    assign command_value   = {15'h0000, io_enable_reg};
    assign mixer_value     = {16'h0000, mixer_base_reg, 7'h00, MIXER_RESET[0]}; // R14 R15

    always_comb begin
        cfg_rdata_next = 32'h0000_0000;
        unique case (cfg_dw_addr_in)
            DW_COMMAND: begin
                cfg_rdata_next = {condition_value, command_value};
            end
            DW_CLASS: begin
                cfg_rdata_next = {BASE_CLASS_VAL, SUBCLASS_VALUE,
                                  PROG_IF_VALUE, REVISION_CODE}; // R8 R9 R10 R11
            end
            DW_HEADER: begin
                cfg_rdata_next = {8'h00, HEADER_VALUE, 16'h0000}; // R12
            end
            DW_MIXER: begin
                cfg_rdata_next = mixer_value; // R13
            end
            default: begin
                cfg_rdata_next = 32'h0000_0000;
            end
        endcase
    end

    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            cfg_rdata_out <= 32'h0000_0000;
            cfg_ack_out   <= 1'b0;
        end else begin
            cfg_ack_out <= cfg_rd_in || cfg_wr_in;
            if (cfg_rd_in) begin
                cfg_rdata_out <= cfg_rdata_next;
            end
        end
    end

    // ************************************************************
    // Mixer window forwarding
    // ************************************************************
    mixer_window_decode window_inst (
        .enable_in     (io_enable_reg),
        .base_in       (mixer_base_reg),
        .addr_in       (io_addr_in),
        .hit_out       (win_hit),
        .secondary_out (win_secondary),
        .offset_out    (win_offset)
    );

    // One access in flight; a second is left unclaimed so the host retries
    assign io_claim_out = io_req_in && win_hit && !busy_reg; // R16 R18

    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            busy_reg <= 1'b0;
        end else if (io_claim_out) begin
            busy_reg <= 1'b1;
        end else if (codec_done_in) begin
            busy_reg <= 1'b0;
        end
    end

    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            codec_req_out       <= 1'b0;
            codec_wr_out        <= 1'b0;
            codec_secondary_out <= 1'b0;
            codec_offset_out    <= 7'h00;
            codec_wdata_out     <= 16'h0000;
        end else begin
            codec_req_out <= io_claim_out; // R16
            if (io_claim_out) begin
                codec_wr_out        <= io_wr_in;
                codec_secondary_out <= win_secondary; // R17
                codec_offset_out    <= win_offset;
                codec_wdata_out     <= io_wdata_in;
            end
        end
    end

    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            io_done_out  <= 1'b0;
            io_rdata_out <= 16'h0000;
        end else begin
            io_done_out <= codec_done_in && busy_reg;
            if (codec_done_in && busy_reg) begin
                io_rdata_out <= codec_rdata_in; // R16
            end
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!rst_n_in);

    a_abort_sets: assert property (master_abort_in |=> abort_flag) // R3
        else $error("abort flag not set after master abort");
    a_abort_clear: assert property (abort_clear && !master_abort_in |=> !abort_flag) // R4
        else $error("abort flag not cleared by write of one");
    a_abort_keep_zero: assert property ( // R4
        abort_flag && !abort_clear |=> abort_flag)
        else $error("abort flag lost without clear");
    a_abort_race_set: assert property (abort_clear && master_abort_in |=> abort_flag) // R19
        else $error("clear beat a simultaneous abort");
    a_decode_en_wr: assert property ( // R18
        wr_cmd && cfg_be_in[0] |=> io_enable_reg == $past(cfg_wdata_in[DECODE_EN_BIT]))
        else $error("decode enable not written");
    a_decode_en_keep: assert property ( // R18
        !(wr_cmd && cfg_be_in[0]) |=> $stable(io_enable_reg))
        else $error("decode enable moved without write");
    // Reset is synchronous, so state settles one edge before release is seen
    a_reset_values: assert property ( // R1 R13 R18
        $rose(rst_n_in) |-> !abort_flag && !io_enable_reg && mixer_base_reg == MIXER_BASE_RST)
        else $error("state not at reset values");

    // ************************************************************
    // Configuration read-back
    // ************************************************************
    a_condition_fixed: assert property ( // R1 R2 R5 R6 R7
        cfg_rd_in && cfg_dw_addr_in == DW_COMMAND
        |=> (cfg_rdata_out[31:16] & 16'hdfff) == CONDITION_RESET)
        else $error("fixed condition bits wrong");
    a_abort_readback: assert property ( // R3 R4
        cfg_rd_in && cfg_dw_addr_in == DW_COMMAND
        |=> cfg_rdata_out[16 + ABORT_BIT] == $past(abort_flag))
        else $error("abort flag read back wrong");
    a_back_to_back: assert property ( // R6
        cfg_rd_in && cfg_dw_addr_in == DW_COMMAND |=> cfg_rdata_out[16 + B2B_BIT])
        else $error("back-to-back capability bit not set");
    a_speed_field: assert property ( // R5
        cfg_rd_in && cfg_dw_addr_in == DW_COMMAND
        |=> cfg_rdata_out[16 + SPEED_LSB +: 2] == CONDITION_RESET[SPEED_LSB +: 2])
        else $error("decode speed field wrong");
    a_class_read: assert property ( // R9 R10 R11
        cfg_rd_in && cfg_dw_addr_in == DW_CLASS
        |=> cfg_ack_out && cfg_rdata_out[31:8] == 24'h07_0300)
        else $error("class bytes wrong");
    a_revision_read: assert property ( // R8
        cfg_rd_in && cfg_dw_addr_in == DW_CLASS |=> cfg_rdata_out[7:0] == REVISION_CODE)
        else $error("revision code wrong");
    a_header_read: assert property ( // R12
        cfg_rd_in && cfg_dw_addr_in == DW_HEADER |=> cfg_rdata_out[23:16] == 8'h00)
        else $error("header layout byte wrong");
    a_mixer_low_bits: assert property ( // R14 R15
        cfg_rd_in && cfg_dw_addr_in == DW_MIXER
        |=> cfg_rdata_out[31:16] == 16'h0000 && cfg_rdata_out[7:0] == 8'h01)
        else $error("mixer base fixed bits wrong");
    a_mixer_base_rb: assert property ( // R15
        cfg_rd_in && cfg_dw_addr_in == DW_MIXER
        |=> cfg_rdata_out[15:8] == $past(mixer_base_reg))
        else $error("mixer base read back wrong");

    // ************************************************************
    // Mixer window and forwarding checks
    // ************************************************************
    a_mixer_base_wr: assert property ( // R15
        wr_mixer && cfg_be_in[1] |=> mixer_base_reg == $past(cfg_wdata_in[15:8]))
        else $error("mixer base not written");
    a_mixer_base_keep: assert property ( // R15
        !(wr_mixer && cfg_be_in[1]) |=> $stable(mixer_base_reg))
        else $error("mixer base moved without write");
    a_no_decode_off: assert property (!io_enable_reg |-> !io_claim_out) // R18
        else $error("claim with decode disabled");
    a_miss_no_claim: assert property ( // R15
        io_addr_in[15:BASE_LSB] != mixer_base_reg |-> !io_claim_out)
        else $error("claim outside the mixer window");
    a_forward_route: assert property ( // R16 R17
        io_claim_out |=> codec_req_out && codec_secondary_out == $past(io_addr_in[7]))
        else $error("forward or routing wrong");
    a_offset_route: assert property ( // R17
        io_claim_out |=> codec_offset_out == $past(io_addr_in[6:0]))
        else $error("codec offset wrong");
    a_write_forward: assert property ( // R16
        io_claim_out
        |=> codec_wr_out == $past(io_wr_in) && codec_wdata_out == $past(io_wdata_in))
        else $error("write kind or data not forwarded");
    a_no_fwd_idle: assert property (!io_claim_out |=> !codec_req_out) // R16 R18
        else $error("codec request without claim");
    a_single_fwd: assert property (codec_req_out |=> !codec_req_out) // R16
        else $error("codec request longer than one cycle");
    a_done_return: assert property ( // R16
        codec_done_in && busy_reg |=> io_done_out && io_rdata_out == $past(codec_rdata_in))
        else $error("codec answer not returned");

    // ************************************************************
    // Main scenarios
    // ************************************************************
    c_abort_cleared: cover property (abort_flag ##1 abort_clear ##1 !abort_flag);
    c_primary_fwd: cover property (io_claim_out && !io_addr_in[7] ##1 codec_req_out);
    c_secondary_done: cover property (codec_req_out && codec_secondary_out ##[1:20] io_done_out);
    c_abort_race: cover property (abort_clear && master_abort_in);
    // Slow answers exercise the busy window that refuses a second access
    c_slow_codec: cover property (codec_req_out ##[5:8] codec_done_in);
endmodule
`default_nettype wire

// *** tb/codec_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module codec_model (
    input  wire logic        clock_in,
    input  wire logic        req_in,
    input  wire logic        wr_in,
    input  wire logic        sec_in,
    input  wire logic [6:0]  offset_in,
    input  wire logic [15:0] wdata_in,
    output logic             done_out,
    output logic [15:0]      rdata_out
);
    // ****************************************
    // Codec register files, primary and secondary
    // ****************************************
    logic [15:0] mem [256];
    logic [2:0]  wait_reg = 3'h0;
    logic        busy_reg = 1'b0;
    logic        slow_reg = 1'b0;
    initial begin
        for (int i = 0; i < 256; i++) mem[i] = 16'hc000 | 16'(i);
        done_out = 1'b0;
        rdata_out = 16'h0000;
    end
    always @(posedge clock_in) begin
        done_out <= 1'b0;
        rdata_out <= ~rdata_out; // Stale data must not look valid
        if (req_in && !busy_reg) begin
            busy_reg <= 1'b1;
            wait_reg <= slow_reg ? 3'h4 : 3'h0; // Prompt and slow answers alternate
            slow_reg <= ~slow_reg;
        end else if (busy_reg && wait_reg != 3'h0) begin
            wait_reg <= wait_reg - 3'h1;
        end else if (busy_reg) begin
            busy_reg <= 1'b0;
            done_out <= 1'b1;
            if (wr_in) mem[{sec_in, offset_in}] <= wdata_in;
            else rdata_out <= mem[{sec_in, offset_in}];
        end
    end
endmodule
`default_nettype wire

// *** tb/tb_top.sv ***
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    import modem_cfg_pkg::*;
    localparam logic [7:0]  REV = 8'h5c; // Arbitrary value
    localparam logic [31:0] ONE = 32'h0000_0001;
    logic        clock_in = 1'b0, rst_n_in = 1'b0, master_abort_in = 1'b0;
    logic        cfg_rd_in = 1'b0, cfg_wr_in = 1'b0, cfg_ack_out;
    logic [5:0]  cfg_dw_addr_in = 6'h00;
    logic [3:0]  cfg_be_in = 4'h0;
    logic [31:0] cfg_wdata_in = 32'h0000_0000, cfg_rdata_out;
    logic        io_req_in = 1'b0, io_wr_in = 1'b0, io_claim_out, io_done_out;
    logic [15:0] io_addr_in = 16'h0000, io_wdata_in = 16'h0000, io_rdata_out;
    logic        codec_req_out, codec_wr_out, codec_secondary_out, codec_done_in;
    logic [6:0]  codec_offset_out;
    logic [15:0] codec_wdata_out, codec_rdata_in;
    int          fails = 0, tests_run = 0;
    always #50 clock_in = ~clock_in;
    modem_pci_config_header #(.REVISION_CODE(REV)) modem_pci_config_header_i (
        .clock_in(clock_in), .rst_n_in(rst_n_in), .cfg_rd_in(cfg_rd_in),
        .cfg_wr_in(cfg_wr_in), .cfg_dw_addr_in(cfg_dw_addr_in), .cfg_be_in(cfg_be_in),
        .cfg_wdata_in(cfg_wdata_in), .cfg_ack_out(cfg_ack_out),
        .cfg_rdata_out(cfg_rdata_out), .master_abort_in(master_abort_in),
        .io_req_in(io_req_in), .io_wr_in(io_wr_in), .io_addr_in(io_addr_in),
        .io_wdata_in(io_wdata_in), .io_claim_out(io_claim_out), .io_done_out(io_done_out),
        .io_rdata_out(io_rdata_out), .codec_req_out(codec_req_out),
        .codec_wr_out(codec_wr_out), .codec_secondary_out(codec_secondary_out),
        .codec_offset_out(codec_offset_out), .codec_wdata_out(codec_wdata_out),
        .codec_done_in(codec_done_in), .codec_rdata_in(codec_rdata_in));
    codec_model codec_model_i (
        .clock_in(clock_in), .req_in(codec_req_out), .wr_in(codec_wr_out),
        .sec_in(codec_secondary_out), .offset_in(codec_offset_out),
        .wdata_in(codec_wdata_out), .done_out(codec_done_in), .rdata_out(codec_rdata_in));
    // ****************************************
    // Access and compare tasks
    // ****************************************
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected %s: expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic cfg(input logic wr, input logic [5:0] a, input logic [3:0] be,
                       input logic [31:0] d);
        cfg_wr_in = wr;
        cfg_rd_in = !wr;
        cfg_dw_addr_in = a;
        cfg_be_in = be;
        cfg_wdata_in = d;
        @(negedge clock_in);
        cfg_wr_in = 1'b0;
        cfg_rd_in = 1'b0;
        master_abort_in = 1'b0;
        check("cfg_ack_out", 32'(cfg_ack_out), ONE);
        @(negedge clock_in);
    endtask
    task automatic rd(input logic [5:0] a, input logic [31:0] exp);
        cfg(1'b0, a, 4'h0, 32'h0000_0000);
        check("cfg_rdata_out", cfg_rdata_out, exp);
    endtask
    task automatic io(input logic wr, input logic [15:0] a, input logic [15:0] d,
                      input logic claim, input logic [15:0] exp);
        io_req_in = 1'b1;
        io_wr_in = wr;
        io_addr_in = a;
        io_wdata_in = d;
        #1 check("io_claim_out", 32'(io_claim_out), 32'(claim));
        @(negedge clock_in);
        io_req_in = 1'b0;
        check("codec_req_out", 32'(codec_req_out), 32'(claim));
        if (claim) begin
            check("codec_secondary_out", 32'(codec_secondary_out), 32'(a[7]));
            check("codec_offset_out", 32'(codec_offset_out), 32'(a[6:0]));
            check("codec_wr_out", 32'(codec_wr_out), 32'(wr));
            if (wr) check("codec_wdata_out", 32'(codec_wdata_out), 32'(d));
            for (int n = 0; n < 20 && io_done_out !== 1'b1; n++) @(negedge clock_in);
            check("io_done_out", 32'(io_done_out), ONE);
            if (!wr) check("io_rdata_out", 32'(io_rdata_out), 32'(exp));
        end
        @(negedge clock_in);
    endtask
    task automatic complete_run;
        $display("comparisons %0d, mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // ****************************************
    // Test sequence
    // ****************************************
    initial begin
        repeat (10) @(negedge clock_in);
        rst_n_in = 1'b1;
        rd(6'h01, 32'h0280_0000);
        rd(6'h02, {8'h07, 8'h03, 8'h00, REV});
        rd(6'h03, 32'h0000_0000);
        rd(6'h04, 32'h0000_0001);
        cfg(1'b1, 6'h01, 4'hf, 32'hffff_fffe);
        rd(6'h01, 32'h0280_0000);
        io(1'b0, 16'h0005, 16'h0000, 1'b0, 16'h0000);
        cfg(1'b1, 6'h04, 4'hf, 32'hffff_ffff);
        rd(6'h04, 32'h0000_ff01);
        cfg(1'b1, 6'h04, 4'h2, 32'h0000_1200);
        rd(6'h04, 32'h0000_1201);
        io(1'b0, 16'h1205, 16'h0000, 1'b0, 16'h0000);
        cfg(1'b1, 6'h01, 4'h1, 32'h0000_0001);
        rd(6'h01, 32'h0280_0001);
        io(1'b0, 16'h1205, 16'h0000, 1'b1, 16'hc005);
        io(1'b1, 16'h1285, 16'hbeef, 1'b1, 16'h0000);
        io(1'b0, 16'h1285, 16'h0000, 1'b1, 16'hbeef);
        io(1'b0, 16'h12fe, 16'h0000, 1'b1, 16'hc0fe);
        io(1'b0, 16'h1305, 16'h0000, 1'b0, 16'h0000);
        master_abort_in = 1'b1;
        @(negedge clock_in);
        master_abort_in = 1'b0;
        rd(6'h01, 32'h2280_0001);
        cfg(1'b1, 6'h01, 4'h8, 32'h0000_0000);
        rd(6'h01, 32'h2280_0001);
        cfg(1'b1, 6'h01, 4'h8, 32'h2000_0000);
        rd(6'h01, 32'h0280_0001);
        master_abort_in = 1'b1;
        cfg(1'b1, 6'h01, 4'h8, 32'h2000_0000);
        rd(6'h01, 32'h2280_0001);
        rst_n_in = 1'b0;
        @(negedge clock_in);
        rst_n_in = 1'b1;
        rd(6'h01, 32'h0280_0000);
        rd(6'h04, 32'h0000_0001);
        complete_run();
    end
    initial begin
        #200_000;
        fails++;
        complete_run();
    end
endmodule
`default_nettype wire
